/* src/sro_defs.vh */
// Constants for the sync-reference output state and delay block
`ifndef SRO_DEFS_VH
`define SRO_DEFS_VH

// ============================================================
// Register offsets
`define SRO_ADDR_W          8
`define SRO_OFF_CTRL        8'h00
`define SRO_OFF_ROLE        8'h01
`define SRO_OFF_BIAS        8'h02
`define SRO_OFF_PDN         8'h03
`define SRO_OFF_VCXO_CFG    8'h04
`define SRO_OFF_VCXO_KEY    8'h05
`define SRO_OFF_GDLY        8'h06
`define SRO_OFF_STATUS      8'h07
`define SRO_OFF_VCXO_ACT    8'h08
`define SRO_OFF_CDLY0       8'h10
`define SRO_OFF_RDLY0       8'h20

// ============================================================
// Field positions
`define SRO_CTRL_BYPASS     0
`define SRO_CTRL_BIAS_TYPE  1
`define SRO_CTRL_START      2
`define SRO_CTRL_STOP       3
`define SRO_VCFG_PON        0
`define SRO_VCFG_STYLE      1
`define SRO_VCFG_SWING_LO   2
`define SRO_VCFG_SWING_HI   3

// ============================================================
// Values
`define SRO_KEY_VALUE       8'h4B
`define SRO_DLY_RESET       8'h00
`define SRO_VCFG_RESET      4'h0
`define SRO_SWING_ADVISED   2'h1
`define SRO_VCO_PERIOD_PS   407
`define SRO_FINE_STEPS      8

// ============================================================
// Output drive levels (2-bit drive code)
`define SRO_LVL_LOW         2'h0
`define SRO_LVL_XPT         2'h1
`define SRO_LVL_TOGGLE      2'h2
`define SRO_LVL_OFF         2'h3

`endif

/* src/sro_phase_dly.v */
// Per-channel delay counter in VCO or VCXO unit periods
`timescale 1ns/1ps
module sro_phase_dly #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         mclk_i,
    input  wire         reset_i,
    // Control
    input  wire         start_i,
    input  wire [W-1:0] units_i,
    input  wire         unit_tick_i,
    // Result
    output reg          done_o,
    output reg          busy_o
);
    reg [W-1:0] cnt_reg;

    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_reg <= {W{1'b0}};
            done_o  <= 1'b0;
            busy_o  <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                if (units_i == {W{1'b0}}) begin
                    done_o <= 1'b1;
                    busy_o <= 1'b0;
                end else begin
                    cnt_reg <= units_i;
                    busy_o  <= 1'b1;
                end
            end else if (busy_o && unit_tick_i) begin
                if (cnt_reg == {{(W-1){1'b0}}, 1'b1}) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // sro_phase_dly

/* src/sro_top.v */
// Sync-reference output state control, VCXO commit and phase delays
`timescale 1ns/1ps
`include "sro_defs.vh"
module sro_top #(
    parameter NREF = 7,
    parameter NCLK = 8
) (
    // Clock and reset
    input  wire                   mclk_i,
    input  wire                   reset_i,
    // Register port
    input  wire [`SRO_ADDR_W-1:0] addr_i,
    input  wire [7:0]             wdata_i,
    input  wire                   wr_i,
    input  wire                   rd_i,
    output reg  [7:0]             rdata_o,
    // Timing ticks from the analog side
    input  wire                   vco_tick_i,
    input  wire                   vcxo_tick_i,
    input  wire [NCLK-1:0]        clk_phase_i,
    input  wire                   sysref_pulse_i,
    input  wire [NCLK-1:0]        half_period_code_ok_i,
    // Output controls
    output reg  [NREF*2-1:0]      ref_level_o,
    output reg  [NREF*3-1:0]      ref_fine_o,
    output reg  [NCLK-1:0]        clk_invert_o,
    output reg  [NCLK-1:0]        clk_aligned_o,
    output reg  [3:0]             vcxo_cfg_o,
    output reg                    event_active_o
);
    // ============================================================
    // Registers
    reg [7:0]      ctrl_reg;
    reg [NREF-1:0] role_reg;
    reg [NREF-1:0] bias_reg;
    reg [NREF-1:0] pdn_reg;
    reg [3:0]      vcfg_pend_reg;
    reg [7:0]      gdly_reg;
    reg [7:0]      cdly_reg [0:NCLK-1];
    reg [5:0]      rdly_reg [0:NREF-1];
    reg [7:0]      rdata_next;

    wire bypass    = ctrl_reg[`SRO_CTRL_BYPASS];
    wire bias_type = ctrl_reg[`SRO_CTRL_BIAS_TYPE];
    // Unit period follows the bypass select
    wire unit_tick  = bypass ? vcxo_tick_i : vco_tick_i;
    reg  half_tick_reg;
    wire gunit_tick = unit_tick & half_tick_reg;

    wire start_cmd = wr_i && addr_i == `SRO_OFF_CTRL &&
                     wdata_i[`SRO_CTRL_START];
    wire stop_cmd  = wr_i && addr_i == `SRO_OFF_CTRL &&
                     wdata_i[`SRO_CTRL_STOP];

    integer k;
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_reg      <= 8'h00;
            role_reg      <= {NREF{1'b0}};
            bias_reg      <= {NREF{1'b0}};
            pdn_reg       <= {NREF{1'b0}};
            vcfg_pend_reg <= `SRO_VCFG_RESET;
            vcxo_cfg_o    <= `SRO_VCFG_RESET;
            gdly_reg      <= `SRO_DLY_RESET;
            for (k = 0; k < NCLK; k = k + 1)
                cdly_reg[k] <= `SRO_DLY_RESET;
            for (k = 0; k < NREF; k = k + 1)
                rdly_reg[k] <= 6'h00;
            half_tick_reg <= 1'b0;
        end else begin
            // Restart the two-unit phase so every global step is exact
            if (start_cmd && !event_active_o)
                half_tick_reg <= 1'b0;
            else if (unit_tick)
                half_tick_reg <= ~half_tick_reg;
            if (wr_i) begin
                if (addr_i == `SRO_OFF_CTRL)
                    ctrl_reg <= {6'h00, wdata_i[1:0]};
                if (addr_i == `SRO_OFF_ROLE)
                    role_reg <= wdata_i[NREF-1:0];
                if (addr_i == `SRO_OFF_BIAS)
                    bias_reg <= wdata_i[NREF-1:0];
                if (addr_i == `SRO_OFF_PDN)
                    pdn_reg <= wdata_i[NREF-1:0];
                if (addr_i == `SRO_OFF_VCXO_CFG)
                    vcfg_pend_reg <= wdata_i[3:0];
                // Staged config is applied only on the key write
                if (addr_i == `SRO_OFF_VCXO_KEY &&
                    wdata_i == `SRO_KEY_VALUE)
                    vcxo_cfg_o <= vcfg_pend_reg;
                if (addr_i == `SRO_OFF_GDLY)
                    gdly_reg <= wdata_i;
                for (k = 0; k < NCLK; k = k + 1)
                    if (addr_i == `SRO_OFF_CDLY0 + k[7:0])
                        cdly_reg[k] <= wdata_i;
                for (k = 0; k < NREF; k = k + 1)
                    if (addr_i == `SRO_OFF_RDLY0 + k[7:0])
                        rdly_reg[k] <= wdata_i[5:0];
            end
        end
    end

    // ============================================================
    // SYSREF event state machine
    localparam ST_IDLE  = 2'h0;
    localparam ST_GDLY  = 2'h1;
    localparam ST_RUN   = 2'h2;
    localparam ST_DONE  = 2'h3;

    reg  [1:0] state_reg;
    reg  [1:0] state_next;
    wire       gdly_done;
    wire       gdly_busy;

    sro_phase_dly #(
        .W (8)
    ) u_gdly (
        .mclk_i      (mclk_i),
        .reset_i     (reset_i),
        .start_i     (state_reg == ST_IDLE && start_cmd),
        .units_i     (gdly_reg),
        .unit_tick_i (gunit_tick),
        .done_o      (gdly_done),
        .busy_o      (gdly_busy)
    );

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (start_cmd) state_next = ST_GDLY;
            ST_GDLY: if (gdly_done) state_next = ST_RUN;
            ST_RUN:  if (stop_cmd)  state_next = ST_DONE;
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg      <= ST_IDLE;
            event_active_o <= 1'b0;
        end else begin
            state_reg      <= state_next;
            event_active_o <= (state_next == ST_GDLY) ||
                              (state_next == ST_RUN);
        end
    end

    // ============================================================
    // SYSREF output levels and coarse delay, per output
    wire [NREF*2-1:0] lvl_next;
    wire [NREF*3-1:0] fine_next;
    wire              event_run  = (state_reg == ST_RUN);
    wire              event_hold = (state_reg == ST_RUN) ||
                                   (state_reg == ST_GDLY);
    wire              cdly_start = (state_reg == ST_GDLY) && gdly_done;

    genvar g;
    generate
        for (g = 0; g < NREF; g = g + 1) begin : g_ref
            wire       cdone;
            reg        arm_reg;
            reg  [1:0] lvl_sel;
            sro_phase_dly #(
                .W (3)
            ) u_cdly (
                .mclk_i      (mclk_i),
                .reset_i     (reset_i),
                .start_i     (cdly_start),
                .units_i     (rdly_reg[g][2:0]),
                .unit_tick_i (unit_tick),
                .done_o      (cdone),
                .busy_o      ()
            );
            // Output is armed once its own coarse delay has run out
            always @(posedge mclk_i or posedge reset_i) begin
                if (reset_i)
                    arm_reg <= 1'b0;
                else if (!event_hold)
                    arm_reg <= 1'b0;
                else if (cdone)
                    arm_reg <= 1'b1;
            end
            // Power-down and role win over event logic; event logic overrides bias enables
            always @* begin
                if (pdn_reg[g])
                    lvl_sel = `SRO_LVL_OFF;
                else if (!role_reg[g])
                    lvl_sel = `SRO_LVL_TOGGLE;
                else if (arm_reg && event_run)
                    lvl_sel = sysref_pulse_i ? `SRO_LVL_TOGGLE :
                        `SRO_LVL_LOW;
                else if (bias_reg[g])
                    lvl_sel = `SRO_LVL_XPT;
                else if (bias_type)
                    lvl_sel = `SRO_LVL_XPT;
                else
                    lvl_sel = `SRO_LVL_LOW;
            end
            assign lvl_next[g*2 +: 2]  = lvl_sel;
            assign fine_next[g*3 +: 3] = rdly_reg[g][5:3];
        end
    endgenerate

    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ref_level_o <= {NREF{`SRO_LVL_LOW}};
            ref_fine_o  <= {(NREF*3){1'b0}};
        end else begin
            ref_level_o <= lvl_next;
            ref_fine_o  <= fine_next;
        end
    end

    // ============================================================
    // Clock channel phase delay and inversion
    wire [NCLK-1:0] cd_done;
    reg  [NCLK-1:0] ph_q_reg;
    reg             ph_live_reg;

    generate
        for (g = 0; g < NCLK; g = g + 1) begin : g_clk
            sro_phase_dly #(
                .W (8)
            ) u_ckdly (
                .mclk_i      (mclk_i),
                .reset_i     (reset_i),
                .start_i     (clk_phase_i[g] & ~ph_q_reg[g] & ph_live_reg),
                .units_i     (cdly_reg[g]),
                .unit_tick_i (unit_tick),
                .done_o      (cd_done[g]),
                .busy_o      ()
            );
        end
    endgenerate

    // First edge after reset only loads the pin level, so no false edge
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ph_live_reg   <= 1'b0;
            ph_q_reg      <= {NCLK{1'b0}};
            clk_aligned_o <= {NCLK{1'b0}};
            clk_invert_o  <= {NCLK{1'b0}};
        end else begin
            ph_live_reg   <= 1'b1;
            ph_q_reg      <= clk_phase_i;
            clk_aligned_o <= cd_done;
            clk_invert_o  <= half_period_code_ok_i;
        end
    end

    // ============================================================
    // Read data
    integer j;
    always @* begin
        rdata_next = 8'h00;
        case (addr_i)
            `SRO_OFF_CTRL:     rdata_next = ctrl_reg;
            `SRO_OFF_ROLE:     rdata_next = {{(8-NREF){1'b0}}, role_reg};
            `SRO_OFF_BIAS:     rdata_next = {{(8-NREF){1'b0}}, bias_reg};
            `SRO_OFF_PDN:      rdata_next = {{(8-NREF){1'b0}}, pdn_reg};
            `SRO_OFF_VCXO_CFG: rdata_next = {4'h0, vcfg_pend_reg};
            `SRO_OFF_VCXO_ACT: rdata_next = {4'h0, vcxo_cfg_o};
            `SRO_OFF_GDLY:     rdata_next = gdly_reg;
            `SRO_OFF_STATUS:   rdata_next = {5'h00, gdly_busy, state_reg};
            default:           rdata_next = 8'h00;
        endcase
        for (j = 0; j < NCLK; j = j + 1)
            if (addr_i == `SRO_OFF_CDLY0 + j[7:0])
                rdata_next = cdly_reg[j];
        for (j = 0; j < NREF; j = j + 1)
            if (addr_i == `SRO_OFF_RDLY0 + j[7:0])
                rdata_next = {2'h0, rdly_reg[j]};
    end

    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i)
            rdata_o <= 8'h00;
        else
            rdata_o <= rd_i ? rdata_next : 8'h00;
    end
endmodule // sro_top

/* tb/sro_checker_assertions.sv */
// Port checker for the sync-reference output block
`timescale 1ns/1ps
module sro_checker #(
    parameter NREF = 7
) (
    input wire              mclk_i,
    input wire              reset_i,
    input wire [7:0]        addr_i,
    input wire [7:0]        wdata_i,
    input wire              wr_i,
    input wire              rd_i,
    input wire [7:0]        rdata_o,
    input wire [NREF*3-1:0] ref_fine_o,
    input wire [3:0]        vcxo_cfg_o,
    input wire              event_active_o
);
    wire start_w = wr_i && addr_i == 8'h00 && wdata_i[2];
    wire stop_w  = wr_i && addr_i == 8'h00 && wdata_i[3];
    wire key_w   = wr_i && addr_i == 8'h05 && wdata_i == 8'h4B;
    wire nokey_w = wr_i && addr_i == 8'h05 && wdata_i != 8'h4B;
    wire fine_w  = wr_i && addr_i == 8'h20;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    sequence s_up; ##[1:2] event_active_o; endsequence
    sequence s_down; ##[1:3] !event_active_o; endsequence
    property p_rd_quiet; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
    a_rd_quiet: assert property (p_rd_quiet)
        else $error("read data outside its slot");
    property p_unmapped; rd_i && addr_i == 8'h0F |=> rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_start; start_w |-> s_up; endproperty
    a_start: assert property (p_start)
        else $error("event did not start");
    property p_stop; stop_w && event_active_o |-> s_down; endproperty
    a_stop: assert property (p_stop)
        else $error("event did not end");
    property p_rise; $rose(event_active_o) |->
        $past(start_w) || $past(start_w, 2); endproperty
    a_rise: assert property (p_rise)
        else $error("event began without start");
    property p_fall; $fell(event_active_o) |->
        $past(stop_w) || $past(stop_w, 2) || $past(stop_w, 3); endproperty
    a_fall: assert property (p_fall)
        else $error("event ended without stop");
    property p_commit; $changed(vcxo_cfg_o) |->
        $past(key_w) || $past(key_w, 2); endproperty
    a_commit: assert property (p_commit)
        else $error("vcxo config changed without key");
    property p_nokey; nokey_w |=> $stable(vcxo_cfg_o) [*2]; endproperty
    a_nokey: assert property (p_nokey)
        else $error("wrong key applied config");
    property p_fine; fine_w |->
        ##2 ref_fine_o[2:0] == $past(wdata_i[5:3], 2); endproperty
    a_fine: assert property (p_fine)
        else $error("fine code not taken");
endmodule // sro_checker

/* tb/sro_conv_model.sv */
// Converter-side model that notes toggling sync-reference outputs
`timescale 1ns/1ps
module sro_conv_model #(
    parameter NREF = 7
) (
    // Clock and control
    input  wire              mclk_i,
    input  wire              clear_i,
    // Output states from the block
    input  wire [NREF*2-1:0] ref_level_i,
    // Observations
    output reg  [NREF-1:0]   seen_toggle_o
);
    integer k;
    initial seen_toggle_o = {NREF{1'b0}};
    always @(posedge mclk_i) begin
        for (k = 0; k < NREF; k = k + 1) begin
            if (clear_i)
                seen_toggle_o[k] <= 1'b0;
            else if (ref_level_i[2*k +: 2] == 2'h2)
                seen_toggle_o[k] <= 1'b1;
        end
    end
endmodule // sro_conv_model

/* tb/tb.sv */
// Self-checking bench for the sync-reference output block
`timescale 1ns/1ps
module tb;
    reg         mclk_i = 1'b0;
    reg         reset_i = 1'b1;
    reg  [7:0]  addr_i = 8'h00;
    reg  [7:0]  wdata_i = 8'h00;
    reg         wr_i = 1'b0;
    reg         rd_i = 1'b0;
    reg         vco_tick_i = 1'b0;
    reg         vcxo_tick_i = 1'b0;
    reg  [7:0]  clk_phase_i = 8'h00;
    reg         sysref_pulse_i = 1'b0;
    reg  [7:0]  half_ok = 8'h00;
    reg         vcxo_en = 1'b1;
    reg         clr = 1'b0;
    reg         rd_d = 1'b0;
    reg  [7:0]  ph_d = 8'h00;
    reg  [7:0]  rise_d1 = 8'h00;
    reg  [7:0]  rise_d2 = 8'h00;
    reg  [7:0]  half_d = 8'h00;
    reg         ck_on = 1'b0;
    reg         live = 1'b0;
    reg  [31:0] seed = 32'h01771A9D;
    reg  [7:0]  v;
    reg  [7:0]  m;
    reg  [7:0]  exp_q[$];
    reg  [7:0]  msk_q[$];
    wire [7:0]  rdata_o;
    wire [13:0] ref_level_o;
    wire [20:0] ref_fine_o;
    wire [3:0]  vcxo_cfg_o;
    wire        event_active_o;
    wire [6:0]  seen;
    wire [7:0]  clk_inv;
    wire [7:0]  clk_al;
    integer     bad_count = 0;
    integer     check_count = 0;
    integer     i;
    integer     n;
    // ============================================================
    // Helpers
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task chk(input [31:0] seen_v, input [31:0] exp_v);
        begin
            check_count = check_count + 1;
            if (seen_v !== exp_v) begin
                bad_count = bad_count + 1;
                $display("BAD %0t seen %h want %h", $time, seen_v, exp_v);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge mclk_i);
            wr_i <= 1'b0;
            @(posedge mclk_i);
        end
    endtask
    task rd(input [7:0] a, input [7:0] e, input [7:0] mk);
        begin
            exp_q.push_back(e);
            msk_q.push_back(mk);
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge mclk_i);
            rd_i <= 1'b0;
            @(posedge mclk_i);
        end
    endtask
    task settle;
        begin
            repeat (3) @(posedge mclk_i);
            #1;
        end
    endtask
    task clear;
        begin
            clr <= 1'b1;
            @(posedge mclk_i);
            clr <= 1'b0;
        end
    endtask
    task wait_all;
        begin
            n = 0;
            while (seen !== 7'h7F && n < 400) begin
                @(posedge mclk_i);
                n = n + 1;
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", check_count, bad_count);
            if (bad_count == 0 && check_count > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // ============================================================
    // Clock, random ticks and read monitor
    always #4 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        seed <= xs(seed);
        vco_tick_i <= seed[0];
        vcxo_tick_i <= vcxo_en & seed[1];
        sysref_pulse_i <= seed[2];
        clk_phase_i <= seed[15:8];
        half_ok <= seed[23:16];
        rd_d <= rd_i;
        ph_d <= clk_phase_i;
        rise_d1 <= clk_phase_i & ~ph_d;
        rise_d2 <= rise_d1;
        half_d <= half_ok;
        if (live)
            chk(clk_inv, half_d);
        if (ck_on)
            chk(clk_al, rise_d2);
        if (rd_d) begin
            m = msk_q.pop_front();
            chk(rdata_o & m, exp_q.pop_front() & m);
        end
    end
    sro_top dut (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .vco_tick_i(vco_tick_i), .vcxo_tick_i(vcxo_tick_i),
        .clk_phase_i(clk_phase_i), .sysref_pulse_i(sysref_pulse_i),
        .half_period_code_ok_i(half_ok), .ref_level_o(ref_level_o),
        .ref_fine_o(ref_fine_o), .clk_invert_o(clk_inv),
        .clk_aligned_o(clk_al),
        .vcxo_cfg_o(vcxo_cfg_o), .event_active_o(event_active_o));
    sro_conv_model conv (.mclk_i(mclk_i), .clear_i(clr),
        .ref_level_i(ref_level_o), .seen_toggle_o(seen));
    initial begin
        #200000;
        bad_count = bad_count + 1;
        tally_and_finish;
    end
    // ============================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        ck_on <= 1'b1;
        live <= 1'b1;
        for (i = 0; i < 8; i = i + 1)
            rd(8'h10 + i[7:0], 8'h00, 8'hFF);
        for (i = 0; i < 7; i = i + 1)
            rd(8'h20 + i[7:0], 8'h00, 8'hFF);
        rd(8'h06, 8'h00, 8'hFF);
        rd(8'h0F, 8'h00, 8'hFF);
        ck_on <= 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            v = seed[7:0];
            wr(8'h10 + i[7:0], v);
            rd(8'h10 + i[7:0], v, 8'hFF);
        end
        for (i = 0; i < 7; i = i + 1) begin
            v = seed[7:0];
            wr(8'h20 + i[7:0], v);
            rd(8'h20 + i[7:0], v, 8'h3F);
            settle;
            chk(ref_fine_o[3*i +: 3], v[5:3]);
        end
        wr(8'h06, 8'hFF);
        rd(8'h06, 8'hFF, 8'hFF);
        wr(8'h06, 8'h01);
        wr(8'h04, 8'h05);
        settle;
        chk(vcxo_cfg_o, 4'h0);
        wr(8'h05, 8'h4A);
        settle;
        chk(vcxo_cfg_o, 4'h0);
        wr(8'h05, 8'h4B);
        settle;
        chk(vcxo_cfg_o, 4'h5);
        rd(8'h08, 8'h05, 8'h0F);
        wr(8'h01, 8'h7F);
        settle;
        chk(ref_level_o, 14'h0000);
        clear;
        wr(8'h00, 8'h04);
        settle;
        chk(event_active_o, 1'b1);
        wait_all;
        chk(seen, 7'h7F);
        wr(8'h00, 8'h08);
        settle;
        chk(event_active_o, 1'b0);
        chk(ref_level_o, 14'h0000);
        wr(8'h00, 8'h02);
        settle;
        chk(ref_level_o, 14'h1555);
        wr(8'h00, 8'h00);
        wr(8'h02, 8'h01);
        settle;
        chk(ref_level_o, 14'h0001);
        wr(8'h03, 8'h02);
        settle;
        chk(ref_level_o, 14'h000D);
        wr(8'h03, 8'h00);
        wr(8'h02, 8'h00);
        vcxo_en <= 1'b0;
        wr(8'h06, 8'h04);
        clear;
        wr(8'h00, 8'h05);
        repeat (30) @(posedge mclk_i);
        rd(8'h07, 8'h04, 8'h04);
        chk(seen, 7'h00);
        vcxo_en <= 1'b1;
        wait_all;
        chk(seen, 7'h7F);
        wr(8'h00, 8'h09);
        settle;
        chk(event_active_o, 1'b0);
        tally_and_finish;
    end
endmodule // tb
bind sro_top sro_checker #(.NREF(NREF)) u_chk (.mclk_i(mclk_i),
    .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .ref_fine_o(ref_fine_o),
    .vcxo_cfg_o(vcxo_cfg_o), .event_active_o(event_active_o));
